// ---- verilog/pap_defs.svh ----
`ifndef PAP_DEFS_SVH
`define PAP_DEFS_SVH

// Register indices; byte address is four times the index
`define PAP_IDX_ACCUM_FLAGS 6'h21
`define PAP_IDX_ACCUM_COUNT_HIGH 6'h22
`define PAP_IDX_ACCUM_COUNT_LOW 6'h23
`define PAP_IDX_ACCUM_COUNT_WORD 6'h24
`define PAP_IDX_COMPARE_PIN_DETACH 6'h2C
`define PAP_IDX_FINE_PRESCALE_SELECT 6'h2E
`define PAP_IDX_CONTROL 6'h30
`define PAP_IDX_IRQ_STATUS 6'h31
`define PAP_IDX_IRQ_CLEAR 6'h32
`define PAP_IDX_IRQ_ENABLE 6'h33

// Flag register fields
`define PAP_FLG_EDGE_BIT 0
`define PAP_FLG_OVF_BIT 1

// Control register fields
`define PAP_CTL_TIMER_EN_BIT 0
`define PAP_CTL_ACCUM_EN_BIT 1
`define PAP_CTL_MODE_BIT 2
`define PAP_CTL_EDGE_SEL_BIT 3
`define PAP_CTL_FAST_CLR_BIT 4
`define PAP_CTL_FINE_MODE_BIT 5
`define PAP_CTL_COARSE_LSB 6
`define PAP_CTL_COARSE_MSB 8

// Reset values
`define PAP_RST_BYTE 8'h00
`define PAP_RST_COUNT 16'h0000
`define PAP_RST_CONTROL 9'h000
`define PAP_RST_IRQ 2'h0

// Counting limits
`define PAP_COUNT_MAX 16'hFFFF
`define PAP_GATE_DIV_LAST 6'h3F

`endif

// ---- verilog/pap_pkg.sv ----
`default_nettype none

package pap_pkg;
  typedef enum logic {
    PAP_MODE_EVENT = 1'b0,
    PAP_MODE_GATED = 1'b1
  } pap_mode_e;
  typedef logic [7:0] pap_byte_t;
  typedef logic [15:0] pap_count_t;
endpackage

`default_nettype wire

// ---- verilog/pap_prescaler.sv ----
`include "pap_defs.svh"
`default_nettype none

module pap_prescaler
  import pap_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic run,
  input wire logic fine_mode,
  input wire pap_byte_t fine_value,
  input wire logic [2:0] coarse_select,
  output logic tick,
  output logic div64_tick
);
  pap_byte_t cnt_reg;
  pap_byte_t limit_reg;
  logic [5:0] gate_cnt_reg;

  // Divide limit: fine is value, coarse is a power of two minus one
  wire pap_byte_t coarse_limit = 8'((8'h01 << coarse_select) - 8'h01);
  wire pap_byte_t limit_sel = fine_mode ? fine_value : coarse_limit;
  wire wrap = (cnt_reg == limit_reg);
  wire pap_byte_t cnt_next = (!run || wrap) ? 8'h00 : cnt_reg + 8'h01;

  // New limit only picked up when the next count value is zero
  always_ff @(posedge core_clk) begin
    if (rst) begin
      cnt_reg <= 8'h00;
      limit_reg <= 8'h00;
      tick <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      if (cnt_next == 8'h00) begin
        limit_reg <= limit_sel;
      end
      tick <= run && wrap;
    end
  end

  // Gate clock for timed accumulation; absent while timer stopped
  always_ff @(posedge core_clk) begin
    if (rst || !run) begin
      gate_cnt_reg <= 6'h00;
      div64_tick <= 1'b0;
    end else begin
      gate_cnt_reg <= gate_cnt_reg + 6'h01;
      div64_tick <= (gate_cnt_reg == `PAP_GATE_DIV_LAST);
    end
  end
endmodule

`default_nettype wire

// ---- verilog/pap_top.sv ----
`include "pap_defs.svh"
`default_nettype none

// Summary of operation
// - The overflow flag sets when the count wraps from FFFF to 0000.
// - Writing one clears a flag only while timer or accum enable is set.
// - Edge flag sets on the event edge, or on the gate's trailing edge.
// - With fast clear set, any count access clears both flags while timer or accum enable is set.
// - The count is a 16-bit value readable and writable as two bytes.
// - The accumulator input is synchronised before counting.
// - With detach at 0 and the timer enabled, compare actions drive the channel pin.
// - With detach at 1, the pin holds but the compare flag still sets.
// - Fine mode divides the clock by the select value plus one.
// - A new fine value takes effect only when the prescaler is at zero.
// - Event mode counts falling edges for 0 and rising for 1.
// - In event mode the accumulator runs regardless of the timer enable; gated mode needs it.
// - Coarse mode divides by a power of two from 1 to 128.
module pap_top
  import pap_pkg::*;
#(
  parameter int CHANNELS = 8
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic channel_seven_pin,
  input wire logic [CHANNELS-1:0] compare_match,
  input wire logic [CHANNELS-1:0] compare_level,
  output logic [CHANNELS-1:0] compare_pin_out,
  output logic [CHANNELS-1:0] compare_pin_oe,
  output logic [CHANNELS-1:0] compare_flag_set,
  output logic timer_tick,
  output logic irq
);
  // Register state
  logic [1:0] accum_flags_reg;
  pap_count_t accum_count_reg;
  logic [CHANNELS-1:0] compare_pin_detach_reg;
  pap_byte_t fine_prescale_select_reg;
  logic [8:0] control_reg;
  logic [1:0] irq_status_reg;
  logic [1:0] irq_enable_reg;
  logic wait_reg;
  logic [31:0] rdata_reg;

  // Input synchroniser and edge history
  logic pin_meta_reg;
  logic pin_sync_reg;
  logic pin_prev_reg;

  logic div64_tick;

  // Control fields
  wire timer_enable = control_reg[`PAP_CTL_TIMER_EN_BIT];
  wire accum_enable = control_reg[`PAP_CTL_ACCUM_EN_BIT];
  wire pap_mode_e accum_mode_select =
    pap_mode_e'(control_reg[`PAP_CTL_MODE_BIT]);
  wire accum_edge_select = control_reg[`PAP_CTL_EDGE_SEL_BIT];
  wire fast_flag_clear = control_reg[`PAP_CTL_FAST_CLR_BIT];
  wire fine_prescale_mode = control_reg[`PAP_CTL_FINE_MODE_BIT];
  wire [2:0] coarse_prescale_select =
    control_reg[`PAP_CTL_COARSE_MSB:`PAP_CTL_COARSE_LSB];

  // Bus decode; an access completes on the cycle waitrequest is low
  wire bus_req = avs_read || avs_write;
  wire access = bus_req && !wait_reg;
  wire wr_acc = access && avs_write;
  wire wr_b0 = wr_acc && avs_byteenable[0];
  wire wr_b1 = wr_acc && avs_byteenable[1];
  wire sel_flags = (avs_address == `PAP_IDX_ACCUM_FLAGS);
  wire sel_high = (avs_address == `PAP_IDX_ACCUM_COUNT_HIGH);
  wire sel_low = (avs_address == `PAP_IDX_ACCUM_COUNT_LOW);
  wire sel_word = (avs_address == `PAP_IDX_ACCUM_COUNT_WORD);
  wire sel_detach = (avs_address == `PAP_IDX_COMPARE_PIN_DETACH);
  wire sel_fine = (avs_address == `PAP_IDX_FINE_PRESCALE_SELECT);
  wire sel_ctl = (avs_address == `PAP_IDX_CONTROL);
  wire sel_ists = (avs_address == `PAP_IDX_IRQ_STATUS);
  wire sel_iclr = (avs_address == `PAP_IDX_IRQ_CLEAR);
  wire sel_ien = (avs_address == `PAP_IDX_IRQ_ENABLE);
  wire sel_count = sel_high || sel_low || sel_word;

  // Flag clears need one of the two enables held by software
  wire clear_allowed = timer_enable || accum_enable;
  wire [1:0] w1c_mask = (wr_b0 && sel_flags && clear_allowed) ?
    avs_writedata[1:0] : 2'b00;
  wire fast_clear = access && sel_count && fast_flag_clear &&
    clear_allowed;
  wire [1:0] flag_clear = w1c_mask | {2{fast_clear}};

  // Synchronised pin, active level and edges
  wire active_edge = accum_edge_select ? (pin_sync_reg && !pin_prev_reg)
    : (!pin_sync_reg && pin_prev_reg);
  wire gate_active = accum_edge_select ? !pin_sync_reg : pin_sync_reg;
  wire gate_prev = accum_edge_select ? !pin_prev_reg : pin_prev_reg;
  wire gate_trailing = gate_prev && !gate_active;
  wire is_gated = (accum_mode_select == PAP_MODE_GATED);

  // Accumulator events; only gated counting needs the timer enable
  wire count_inc = accum_enable && (is_gated ?
    (gate_active && div64_tick) : active_edge);
  wire edge_event = accum_enable &&
    (is_gated ? gate_trailing : active_edge);
  wire ovf_event = count_inc && (accum_count_reg == `PAP_COUNT_MAX);
  wire [1:0] flag_set = {ovf_event, edge_event};

  // Count next value: software write beats a same-cycle increment
  wire pap_count_t count_inc_val = accum_count_reg + 16'h0001;
  wire pap_count_t count_base = count_inc ? count_inc_val
    : accum_count_reg;
  wire pap_byte_t count_hi_next =
    (wr_b1 && sel_word) ? avs_writedata[15:8] :
    (wr_b0 && sel_high) ? avs_writedata[7:0] : count_base[15:8];
  wire pap_byte_t count_lo_next =
    (wr_b0 && (sel_word || sel_low)) ? avs_writedata[7:0]
    : count_base[7:0];

  // Read mux; unmapped indices read zero
  wire [31:0] rdata_next =
    sel_flags ? {30'h0, accum_flags_reg} :
    sel_high ? {24'h0, accum_count_reg[15:8]} :
    sel_low ? {24'h0, accum_count_reg[7:0]} :
    sel_word ? {16'h0, accum_count_reg} :
    sel_detach ? {{(32-CHANNELS){1'b0}}, compare_pin_detach_reg} :
    sel_fine ? {24'h0, fine_prescale_select_reg} :
    sel_ctl ? {23'h0, control_reg} :
    sel_ists ? {30'h0, irq_status_reg} :
    sel_ien ? {30'h0, irq_enable_reg} : 32'h0;

  // Two-flop synchroniser plus one history stage for edges
  always_ff @(posedge core_clk) begin
    if (rst) begin
      pin_meta_reg <= 1'b0;
      pin_sync_reg <= 1'b0;
      pin_prev_reg <= 1'b0;
    end else begin
      pin_meta_reg <= channel_seven_pin;
      pin_sync_reg <= pin_meta_reg;
      pin_prev_reg <= pin_sync_reg;
    end
  end

  // Bus handshake: one wait state, read data registered
  always_ff @(posedge core_clk) begin
    if (rst) begin
      wait_reg <= 1'b1;
      rdata_reg <= 32'h0;
    end else begin
      wait_reg <= !(bus_req && wait_reg);
      if (bus_req && wait_reg && avs_read) begin
        rdata_reg <= rdata_next;
      end
    end
  end

  // Flags: a set in the clearing cycle wins
  always_ff @(posedge core_clk) begin
    if (rst) begin
      accum_flags_reg <= `PAP_RST_IRQ;
    end else begin
      accum_flags_reg <= (accum_flags_reg & ~flag_clear) | flag_set;
    end
  end

  // Accumulator count
  always_ff @(posedge core_clk) begin
    if (rst) begin
      accum_count_reg <= `PAP_RST_COUNT;
    end else begin
      accum_count_reg <= {count_hi_next, count_lo_next};
    end
  end

  // Software-written configuration
  always_ff @(posedge core_clk) begin
    if (rst) begin
      compare_pin_detach_reg <= '0;
      fine_prescale_select_reg <= `PAP_RST_BYTE;
      control_reg <= `PAP_RST_CONTROL;
      irq_enable_reg <= `PAP_RST_IRQ;
    end else begin
      if (wr_b0 && sel_detach) begin
        compare_pin_detach_reg <= avs_writedata[CHANNELS-1:0];
      end
      if (wr_b0 && sel_fine) begin
        fine_prescale_select_reg <= avs_writedata[7:0];
      end
      if (wr_b0 && sel_ctl) begin
        control_reg[7:0] <= avs_writedata[7:0];
      end
      if (wr_b1 && sel_ctl) begin
        control_reg[8] <= avs_writedata[8];
      end
      if (wr_b0 && sel_ien) begin
        irq_enable_reg <= avs_writedata[1:0];
      end
    end
  end

  // Sticky interrupt status, write-one clear, set wins
  wire [1:0] irq_clear = (wr_b0 && sel_iclr) ? avs_writedata[1:0] : 2'b00;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      irq_status_reg <= `PAP_RST_IRQ;
      irq <= 1'b0;
    end else begin
      irq_status_reg <= (irq_status_reg & ~irq_clear) | flag_set;
      // Registered level lags the status bit by one cycle
      irq <= |(irq_status_reg & irq_enable_reg);
    end
  end

  // Per-channel compare pin drive; flag passes regardless of detach
  genvar ch;
  generate
    for (ch = 0; ch < CHANNELS; ch++) begin : g_chan
      always_ff @(posedge core_clk) begin
        if (rst) begin
          compare_pin_out[ch] <= 1'b0;
          compare_pin_oe[ch] <= 1'b0;
          compare_flag_set[ch] <= 1'b0;
        end else begin
          compare_pin_oe[ch] <= timer_enable &&
            !compare_pin_detach_reg[ch];
          if (compare_match[ch] && !compare_pin_detach_reg[ch]) begin
            compare_pin_out[ch] <= compare_level[ch];
          end
          compare_flag_set[ch] <= compare_match[ch];
        end
      end
    end
  endgenerate

  // Main timer prescaler, also source of the gate clock
  pap_prescaler u_prescaler (
    .core_clk(core_clk),
    .rst(rst),
    .run(timer_enable),
    .fine_mode(fine_prescale_mode),
    .fine_value(fine_prescale_select_reg),
    .coarse_select(coarse_prescale_select),
    .tick(timer_tick),
    .div64_tick(div64_tick)
  );

  assign avs_waitrequest = wait_reg;
  assign avs_readdata = rdata_reg;
endmodule

`default_nettype wire

// ---- verification/pap_asserts.sv ----
`include "pap_defs.svh"
`default_nettype none

module pap_asserts
  import pap_pkg::*;
#(
  parameter int CHANNELS = 8
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic [CHANNELS-1:0] compare_match,
  input wire logic [CHANNELS-1:0] compare_level,
  input wire logic [CHANNELS-1:0] compare_pin_out,
  input wire logic [CHANNELS-1:0] compare_pin_oe,
  input wire logic [CHANNELS-1:0] compare_flag_set
);
  timeunit 1ns;
  timeprecision 1ps;
  logic req;

  // Any bus request, read or write
  assign req = avs_read | avs_write;

  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);

  wait_answer_a: assert property (req && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus request not answered in one wait state");
  wait_stands_a: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low for more than one cycle");
  idle_wait_a: assert property (!req |=> avs_waitrequest)
    else $error("waitrequest low without a request");
  flag_copy_a: assert property (compare_flag_set == $past(compare_match))
    else $error("compare flag does not follow the match");
  pin_hold_a: assert property (compare_match == 0 |=> $stable(compare_pin_out))
    else $error("pin moved without a match");
  pin_follow_a: assert property (compare_match != 0 |=>
    ((compare_pin_out ^ $past(compare_level)) &
     $past(compare_match & compare_pin_oe)) == 0)
    else $error("driven pin missed its compare level");
  flag_bits_a: assert property (avs_read && !avs_waitrequest &&
    avs_address == `PAP_IDX_ACCUM_FLAGS |-> avs_readdata[7:2] == 0)
    else $error("unused flag bits read nonzero");
  oe_stable_a: assert property (!avs_write && !$past(avs_write) |=>
    $stable(compare_pin_oe))
    else $error("pin enable moved without a register write");
endmodule

bind pap_top pap_asserts #(.CHANNELS(CHANNELS)) i_pap_asserts (
  .core_clk(core_clk),
  .rst(rst),
  .avs_address(avs_address),
  .avs_read(avs_read),
  .avs_write(avs_write),
  .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest),
  .compare_match(compare_match),
  .compare_level(compare_level),
  .compare_pin_out(compare_pin_out),
  .compare_pin_oe(compare_pin_oe),
  .compare_flag_set(compare_flag_set)
);

`default_nettype wire

// ---- verification/pap_pin_model.sv ----
`default_nettype none

module pap_pin_model (
  input wire logic core_clk,
  output logic channel_seven_pin
);
  timeunit 1ns;
  timeprecision 1ps;

  // Level held four clocks, past the two-clock minimum pulse width
  task automatic drive(input logic lvl);
    @(posedge core_clk);
    channel_seven_pin <= lvl;
    repeat (4) @(posedge core_clk);
  endtask

  initial channel_seven_pin = 1'b0;
endmodule

`default_nettype wire

// ---- verification/test_pulse_accum_prescale_pins.sv ----
`default_nettype none

module test_pulse_accum_prescale_pins
  import pap_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [5:0] ra [5] = '{6'h21, 6'h24, 6'h2C, 6'h2E, 6'h3F};
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic [5:0] adr = '0;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [3:0] be = 4'hF;
  logic [31:0] wd = '0;
  logic [7:0] cm = '0;
  logic [7:0] cl = '0;
  logic [31:0] rdata, v, d, pv;
  logic [7:0] pout, oe, fs;
  logic wreq, pin, tick, irq;
  int errors = 0;
  int checks_done = 0;

  // Bus clock, 8 ns period
  always #4 core_clk = ~core_clk;

  pap_top #(.CHANNELS(8)) i_pap_top (
    .core_clk(core_clk), .rst(rst), .avs_address(adr), .avs_read(rd),
    .avs_write(wr), .avs_writedata(wd), .avs_byteenable(be),
    .avs_readdata(rdata), .avs_waitrequest(wreq),
    .channel_seven_pin(pin), .compare_match(cm), .compare_level(cl),
    .compare_pin_out(pout), .compare_pin_oe(oe), .compare_flag_set(fs),
    .timer_tick(tick), .irq(irq));
  pap_pin_model i_pap_pin_model (.core_clk(core_clk),
    .channel_seven_pin(pin));

  task automatic close_out;
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, g);
    checks_done++;
    if (g !== e) begin
      errors++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask

  // Request held until waitrequest is seen low; bounded wait
  task automatic bus(input logic w, input logic [5:0] a,
    input logic [31:0] d, input logic [3:0] bl, output logic [31:0] q);
    int n;
    @(posedge core_clk);
    adr <= a;
    rd <= ~w;
    wr <= w;
    wd <= d;
    be <= bl;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (wreq !== 1'b0 && n < 50);
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
    if (wreq !== 1'b0) begin
      errors++;
      close_out();
    end
  endtask

  task automatic wrr(input logic [5:0] a, input logic [31:0] d,
    input logic [3:0] bl = 4'hF);
    logic [31:0] q;
    bus(1'b1, a, d, bl, q);
  endtask

  task automatic rdc(input logic [5:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, 4'hF, q);
    chk($sformatf("reg %h", a), e, q);
  endtask

  // Irq is registered, so give it two edges to settle
  task automatic irqchk(input logic e);
    repeat (2) @(posedge core_clk);
    chk("irq", {31'h0, e}, {31'h0, irq});
  endtask

  // Third tick gap, well after any pending reload
  task automatic tgap(input logic [31:0] e);
    int n, m, t;
    logic [31:0] g;
    t = 0;
    m = 0;
    g = 0;
    for (n = 0; n < 2000 && t < 3; n++) begin
      @(posedge core_clk);
      if (tick === 1'b1) begin
        t++;
        g = n - m;
        m = n;
      end
    end
    if (t < 3) begin
      errors++;
      close_out();
    end else begin
      chk("tick gap", e, g);
    end
  endtask

  task automatic fin(input int t);
    $display("test %0d done", t);
  endtask

  initial begin
    v = $urandom(32'hAC1714B6);
    repeat (3) @(posedge core_clk);
    rst <= 1'b0;
    foreach (ra[i]) rdc(ra[i], 32'h0);
    fin(1);
    v = $urandom & 32'hFFFF;
    wrr(6'h24, v);
    rdc(6'h24, v);
    rdc(6'h22, v >> 8);
    rdc(6'h23, v & 32'hFF);
    // Single-lane writes touch one byte of the count only
    wrr(6'h24, ~v, 4'h1);
    rdc(6'h24, (v & 32'hFF00) | (~v & 32'hFF));
    wrr(6'h24, ~v, 4'h2);
    rdc(6'h24, ~v & 32'hFFFF);
    fin(2);
    // Timer off, accumulator counting rising then falling edges
    wrr(6'h30, 32'h00A);
    wrr(6'h24, 32'h0);
    i_pap_pin_model.drive(1'b1);
    rdc(6'h24, 32'h1);
    wrr(6'h30, 32'h002);
    i_pap_pin_model.drive(1'b0);
    i_pap_pin_model.drive(1'b1);
    rdc(6'h24, 32'h2);
    rdc(6'h21, 32'h1);
    fin(3);
    wrr(6'h24, 32'hFFFF);
    i_pap_pin_model.drive(1'b0);
    rdc(6'h24, 32'h0);
    rdc(6'h21, 32'h3);
    wrr(6'h30, 32'h0);
    wrr(6'h21, 32'h3);
    rdc(6'h21, 32'h3);
    wrr(6'h30, 32'h2);
    wrr(6'h21, 32'hFE);
    rdc(6'h21, 32'h1);
    rdc(6'h31, 32'h3);
    wrr(6'h33, 32'h2);
    irqchk(1'b1);
    wrr(6'h33, 32'h0);
    irqchk(1'b0);
    wrr(6'h33, 32'h2);
    wrr(6'h32, 32'h2);
    irqchk(1'b0);
    rdc(6'h31, 32'h1);
    fin(4);
    wrr(6'h30, 32'h012);
    rdc(6'h23, 32'h0);
    rdc(6'h21, 32'h0);
    i_pap_pin_model.drive(1'b1);
    i_pap_pin_model.drive(1'b0);
    rdc(6'h21, 32'h1);
    wrr(6'h22, 32'h0);
    rdc(6'h21, 32'h0);
    fin(5);
    // Gated mode, high level active: only the trailing edge flags
    wrr(6'h30, 32'h007);
    i_pap_pin_model.drive(1'b1);
    repeat (140) @(posedge core_clk);
    rdc(6'h21, 32'h0);
    i_pap_pin_model.drive(1'b0);
    rdc(6'h21, 32'h1);
    // Gate active low: the rising pin edge ends it
    wrr(6'h21, 32'h1);
    rdc(6'h21, 32'h0);
    wrr(6'h30, 32'h00F);
    i_pap_pin_model.drive(1'b1);
    rdc(6'h21, 32'h1);
    wrr(6'h33, 32'h1);
    irqchk(1'b1);
    wrr(6'h32, 32'h1);
    irqchk(1'b0);
    rdc(6'h31, 32'h0);
    fin(6);
    wrr(6'h30, 32'h1);
    pv = 32'h0;
    for (int k = 0; k < 3; k++) begin
      d = $urandom & 32'hFF;
      wrr(6'h2C, d);
      rdc(6'h2C, d);
      v = $urandom & 32'hFF;
      @(posedge core_clk);
      cl <= 8'($urandom);
      cm <= v[7:0];
      @(posedge core_clk);
      cm <= 8'h00;
      // Outputs launched at the last edge, looked at mid-cycle
      @(negedge core_clk);
      pv = (32'(cl) & v & ~d) | (pv & ~(v & ~d));
      chk("pin", pv, 32'(pout));
      chk("oe", ~d & 32'hFF, 32'(oe));
      chk("flag", v, 32'(fs));
    end
    fin(7);
    for (int k = 0; k < 5; k++) begin
      v = (k < 2) ? k * 255 : $urandom_range(20, 1);
      wrr(6'h2E, v);
      wrr(6'h30, 32'h21);
      tgap(v + 1);
    end
    for (int s = 0; s < 8; s++) begin
      wrr(6'h30, (s << 6) | 1);
      tgap(1 << s);
    end
    fin(8);
    close_out();
  end
endmodule

`default_nettype wire
